// ==== serial_vid_send_byte_slave_tb.sv ====
// Self-checking bench for the serial voltage link slave
`timescale 1ns/1ns
`default_nettype none
module serial_vid_send_byte_slave_tb;
  typedef struct packed { logic [6:0] adr; logic rw; logic [7:0] dat; logic acc; } svs_row_t;

  logic       clk;                 // Core clock
  logic       rst_b;               // Async reset, low active
  logic       power_ok;            // Processor power-ok level
  logic [6:0] strap;               // Start-up code strap
  logic       link_clk;            // Link clock from master
  logic       link_drv;            // Master data drive
  wire  logic link_wire;           // Resolved open-drain data line
  logic       dout;                // Device data drive value
  logic       oe_n;                // Device drive enable, low = pull
  logic [6:0] code_a, code_b, code_br;  // Plane targets
  logic       off_a, off_b, off_br;     // Plane off flags
  logic       hint_n;              // Power-saving hint
  logic       upd;                 // Targets changed pulse
  logic [6:0] exp_a, exp_b, exp_br;     // Expected targets
  logic       exp_h;               // Expected hint
  int         num_errors;          // Mismatches seen
  int         cmp_count;           // Comparisons made
  int         upd_cnt;             // Update pulses seen

  // Ordinary commands, one loop: address, write bit, data, address acknowledged
  svs_row_t rows [10] = '{
    {7'h62, 1'h0, 8'h90, 1'h1},  // Plane a only, hint high
    {7'h64, 1'h0, 8'h7c, 1'h1},  // Plane b, first off code, hint low
    {7'h61, 1'h0, 8'h7b, 1'h1},  // Bridge, last on code
    {7'h6f, 1'h0, 8'h25, 1'h1},  // All planes plus reserved bit
    {7'h68, 1'h0, 8'h05, 1'h1},  // Reserved bit only: hint alone commits
    {7'h72, 1'h0, 8'h33, 1'h0},  // Broken pattern, refused
    {7'h22, 1'h0, 8'h44, 1'h0},  // Broken pattern, refused
    {7'h63, 1'h1, 8'h11, 1'h0},  // Read direction, refused
    {7'h66, 1'h0, 8'hff, 1'h1},  // Two planes, highest off code
    {7'h6e, 1'h0, 8'h00, 1'h1}   // Two planes plus reserved, top voltage code
  };

  // Pull-up wins unless a party pulls low
  assign link_wire = link_drv & (oe_n | dout);

  svs_slave dut (
    .clk(clk), .rst_b(rst_b), .vid_link_clock(link_clk), .vid_link_data_in(link_wire),
    .vid_link_data_out(dout), .vid_link_data_oe_n(oe_n), .processor_power_ok(power_ok),
    .startup_code(strap), .core_plane_a_code(code_a), .core_plane_b_code(code_b),
    .bridge_plane_code(code_br), .core_plane_a_off(off_a), .core_plane_b_off(off_b),
    .bridge_plane_off(off_br), .power_saving_hint_n(hint_n), .targets_update(upd)
  );

  svs_link_master m (.link_wire(link_wire), .link_clk(link_clk), .link_drv(link_drv));

  // 100 MHz core clock
  initial clk = 1'h0;
  always #5 clk = ~clk;

  // Counts commit pulses so the bench can tell when they land
  initial upd_cnt = 0;
  always @(posedge clk) begin
    if (upd === 1'h1) upd_cnt++;
  end

  // Verdict and end of run, shared with the watchdog
  task automatic complete_run();
    if (num_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_code(input logic [6:0] got, input logic [6:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // All targets, off flags and hint against the bench's own model
  task automatic chk_all();
    chk_code(code_a, exp_a);
    chk_code(code_b, exp_b);
    chk_code(code_br, exp_br);
    chk_bit(off_a, exp_a >= svs_pkg::CODE_OFF_MIN);
    chk_bit(off_b, exp_b >= svs_pkg::CODE_OFF_MIN);
    chk_bit(off_br, exp_br >= svs_pkg::CODE_OFF_MIN);
    chk_bit(hint_n, exp_h);
  endtask

  // Expected targets go back to the strap
  task automatic exp_strap();
    exp_a = strap;
    exp_b = strap;
    exp_br = strap;
    exp_h = 1'h1;
  endtask

  // One command with stop; live low means power-ok is down
  task automatic command(input svs_row_t r, input int cut, input logic live);
    logic aa, ad, good, ok;
    int   n0;
    good = live && r.acc;
    ok = good && cut == 8;
    n0 = upd_cnt;
    m.frame(r.adr, r.rw, r.dat, cut, aa, ad);
    chk_bit(aa, !good);
    if (ok) chk_bit(ad, 1'h0);
    repeat (10) @(posedge clk);
    chk_bit(upd_cnt == n0, 1'h1);
    m.stop_cond();
    // Commit lands a few cycles after the stop; bounded wait
    for (int i = 0; i < 20 && upd_cnt == n0; i++) @(posedge clk);
    repeat (2) @(posedge clk);
    #1;
    chk_bit(upd_cnt == n0 + int'(ok), 1'h1);
    if (ok) begin
      if (r.adr[svs_pkg::SEL_CORE_B_BIT]) exp_b = r.dat[6:0];
      if (r.adr[svs_pkg::SEL_CORE_A_BIT]) exp_a = r.dat[6:0];
      if (r.adr[svs_pkg::SEL_BRIDGE_BIT]) exp_br = r.dat[6:0];
      exp_h = r.dat[svs_pkg::HINT_BIT];
    end
    chk_all();
  endtask

  // Main sequence
  initial begin
    num_errors = 0;
    cmp_count = 0;
    rst_b = 1'h0;
    power_ok = 1'h0;
    strap = 7'h2a;
    repeat (12) @(posedge clk);
    #1 rst_b = 1'h1;
    power_ok = 1'h1;
    repeat (6) @(posedge clk);
    #1;
    exp_strap();
    chk_all();
    chk_bit(oe_n, 1'h1);
    foreach (rows[i]) command(rows[i], 8, 1'h1);
    // Stop in mid data byte: nothing committed
    command({7'h62, 1'h0, 8'h11, 1'h1}, 4, 1'h1);
    // Power-ok loss restores the strap and blinds the link
    power_ok = 1'h0;
    repeat (6) @(posedge clk);
    #1;
    exp_strap();
    chk_all();
    command({7'h62, 1'h0, 8'h10, 1'h1}, 8, 1'h0);
    power_ok = 1'h1;
    repeat (6) @(posedge clk);
    #1;
    command({7'h61, 1'h0, 8'h40, 1'h1}, 8, 1'h1);
    // Second reset in mid-run with a new strap
    rst_b = 1'h0;
    repeat (2) @(posedge clk);
    #1;
    chk_code(code_a, svs_pkg::CODE_RESET);
    chk_bit(hint_n, svs_pkg::HINT_RESET);
    strap = 7'h51;
    rst_b = 1'h1;
    repeat (6) @(posedge clk);
    #1;
    exp_strap();
    chk_all();
    command({7'h64, 1'h0, 8'h8f, 1'h1}, 8, 1'h1);
    complete_run();
  end

  // Watchdog: the whole run needs well under 300 us
  initial begin
    #300000;
    num_errors++;
    complete_run();
  end
endmodule // serial_vid_send_byte_slave_tb
`default_nettype wire

// ==== svs_line_cond.sv ====
// Pin synchroniser and edge, start and stop finder for the link
`timescale 1ns/1ns
`default_nettype none
module svs_line_cond (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic link_clock_pin,
  input  wire logic link_data_pin,
  input  wire logic power_ok_pin,
  svs_line_if.src   line
);

  logic [2:0] clk_sh_r;   // [0] first stage only feeds [1]
  logic [2:0] dat_sh_r;   // Same layout for data
  logic [1:0] pok_sh_r;   // Power-ok two-stage sync

  // Two flops per pin, plus one history flop for clock and data edges
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_sh_r <= 3'h7;
      dat_sh_r <= 3'h7;
      pok_sh_r <= 2'h0;
    end else begin
      clk_sh_r <= {clk_sh_r[1:0], link_clock_pin};
      dat_sh_r <= {dat_sh_r[1:0], link_data_pin};
      pok_sh_r <= {pok_sh_r[0], power_ok_pin};
    end
  end

  // Edges only from stages past the first
  assign line.clk_rise = clk_sh_r[1] & ~clk_sh_r[2];
  assign line.clk_fall = ~clk_sh_r[1] & clk_sh_r[2];
  assign line.data     = dat_sh_r[1];
  // Data moving while clock stays high marks start or stop
  assign line.start    = clk_sh_r[1] & clk_sh_r[2] & ~dat_sh_r[1] & dat_sh_r[2];
  assign line.stop     = clk_sh_r[1] & clk_sh_r[2] & dat_sh_r[1] & ~dat_sh_r[2];
  assign line.power_ok = pok_sh_r[1];

endmodule // svs_line_cond
`default_nettype wire

// ==== svs_line_if.sv ====
// Conditioned link events passed from line conditioner to receiver
`timescale 1ns/1ns
`default_nettype none
interface svs_line_if;
  logic clk_rise;   // Link clock rising edge, one cycle
  logic clk_fall;   // Link clock falling edge, one cycle
  logic data;       // Synchronised data level
  logic start;      // Start condition seen, one cycle
  logic stop;       // Stop condition seen, one cycle
  logic power_ok;   // Synchronised processor power-ok level

  modport src (output clk_rise, output clk_fall, output data,
               output start, output stop, output power_ok);
  modport dst (input clk_rise, input clk_fall, input data,
               input start, input stop, input power_ok);
endinterface
`default_nettype wire

// ==== svs_link_master.sv ====
// Behavioural processor-side master that drives the serial voltage link
`timescale 1ns/1ns
`default_nettype none
module svs_link_master (
  input  wire logic link_wire,  // Resolved data wire level
  output var  logic link_clk,   // Link clock, idles high between frames
  output var  logic link_drv    // Data drive, 1 = released to pull-up
);
  localparam int TLO = 63;  // Low phase in ns, 125 ns period
  localparam int THI = 62;  // High phase in ns

  // Idle bus: both lines released
  initial begin
    link_clk = 1'h1;
    link_drv = 1'h1;
  end

  // One clock, data changed only while low; wire sampled at the rise
  task automatic bit_clk(input logic b, output logic s);
    link_clk = 1'h0;
    #20 link_drv = b;
    #(TLO - 20) link_clk = 1'h1;
    s = link_wire;
    #THI;
  endtask

  // Stop: data rises while the clock is high
  task automatic stop_cond();
    link_clk = 1'h0;
    #20 link_drv = 1'h0;
    #(TLO - 20) link_clk = 1'h1;
    #THI link_drv = 1'h1;
    #THI;
  endtask

  // Start, address, write bit, data; cut below 8 aborts the data byte
  task automatic frame(input logic [6:0] adr, input logic rw, input logic [7:0] dat,
                       input int cut, output logic ack_a, output logic ack_d);
    logic [7:0] ab;
    logic       s;
    ab = {adr, rw};
    ack_d = 1'h1;
    #THI link_drv = 1'h0;
    #THI;
    for (int i = 7; i >= 0; i--) begin
      bit_clk(ab[i], s);
    end
    // Released during ack clock so a missing ack reads high
    bit_clk(1'h1, ack_a);
    if (ack_a === 1'h0) begin
      for (int i = 7; i >= 8 - cut; i--) begin
        bit_clk(dat[i], s);
      end
      if (cut == 8) bit_clk(1'h1, ack_d);
    end
  endtask
endmodule // svs_link_master
`default_nettype wire

// ==== svs_pkg.sv ====
// Shared constants and types for the serial voltage link slave
package svs_pkg;

  // Address byte layout (bits of the 7-bit slave address)
  localparam int          ADDR_PAT_MSB   = 6;      // Fixed pattern top bit
  localparam int          ADDR_PAT_LSB   = 4;      // Fixed pattern bottom bit
  localparam logic [2:0]  ADDR_PATTERN   = 3'h6;   // Always 110b
  localparam int          ADDR_RESV_BIT  = 3;      // Reserved, never decoded
  localparam int          SEL_CORE_B_BIT = 2;      // Second core plane select
  localparam int          SEL_CORE_A_BIT = 1;      // First core plane select
  localparam int          SEL_BRIDGE_BIT = 0;      // Bridge plane select

  // Data byte layout
  localparam int          HINT_BIT       = 7;      // Power-saving hint, low active
  localparam int          CODE_MSB       = 6;      // Voltage code top bit
  localparam int          CODE_W         = 7;      // Voltage code width

  // Codes at or above this turn the plane off
  localparam logic [6:0]  CODE_OFF_MIN   = 7'h7c;
  // Each code step lowers the target by this much, in microvolts
  localparam int          CODE_STEP_UV   = 12500;

  // Bits per byte on the link
  localparam logic [3:0]  BYTE_BITS      = 4'h8;

  // Values after reset
  localparam logic        HINT_RESET     = 1'h1;   // Not in power saving
  localparam logic [6:0]  CODE_RESET     = 7'h00;  // Until strap is caught

  // Receiver states, one-hot
  typedef enum logic [5:0] {
    SVS_IDLE      = 6'h01,  // Waiting for a start
    SVS_ADDR      = 6'h02,  // Shifting in address byte
    SVS_ADDR_ACK  = 6'h04,  // Address acknowledge slot
    SVS_DATA      = 6'h08,  // Shifting in data byte
    SVS_DATA_ACK  = 6'h10,  // Data acknowledge slot
    SVS_WAIT_STOP = 6'h20   // Command held until stop
  } svs_state_t;

endpackage

// ==== svs_slave.sv ====
// Send-byte slave for the serial voltage link, with plane targets
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Address bits 6:4 must read 110b
// - Reserved address bit 3 is ignored
// - Bit 2 selects second core plane
// - Bit 1 selects first core plane
// - Bit 0 selects bridge; several allowed
// - Acknowledge address only when valid
// - Data bit 7 is the hint, low saves
// - Data bits 6:0 are the voltage code
// - Acknowledge data only when code valid
// - Targets move only after the stop or on power-ok loss
// - Start at strapped code, then follow commands
// - Watch link only while power-ok high
// - Code zero highest; 7ch upward means off
module svs_slave #(
  parameter int CODE_WIDTH = svs_pkg::CODE_W     // Voltage code width
) (
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire logic                  vid_link_clock,
  input  wire logic                  vid_link_data_in,
  output var  logic                  vid_link_data_out,
  output var  logic                  vid_link_data_oe_n,
  input  wire logic                  processor_power_ok,
  input  wire logic [CODE_WIDTH-1:0] startup_code,
  output var  logic [CODE_WIDTH-1:0] core_plane_a_code,
  output var  logic [CODE_WIDTH-1:0] core_plane_b_code,
  output var  logic [CODE_WIDTH-1:0] bridge_plane_code,
  output var  logic                  core_plane_a_off,
  output var  logic                  core_plane_b_off,
  output var  logic                  bridge_plane_off,
  output var  logic                  power_saving_hint_n,
  output var  logic                  targets_update
);

  // Logic below is built around the fixed 7-bit code field
  if (CODE_WIDTH != svs_pkg::CODE_W) begin : g_bad_width
    $error("svs_slave: CODE_WIDTH must be 7");
  end

  svs_line_if line ();                 // Conditioned link events

  svs_pkg::svs_state_t state_r;        // Receiver state
  logic [7:0]          shift_r;        // Incoming bits, MSB first
  logic [3:0]          bit_cnt_r;      // Bits taken in this byte
  logic [7:0]          addr_byte_r;    // Latched address byte
  logic [7:0]          data_byte_r;    // Latched data byte
  logic                addr_ok_r;      // Address was acknowledged
  logic                data_ok_r;      // Data was acknowledged
  logic                strap_done_r;   // Start-up code captured
  logic                pok_prev_r;     // Power-ok one cycle ago
  logic                addr_valid;     // Address pattern and write bit
  logic                data_valid;     // Data byte acceptable
  logic                commit;         // Apply pending command now

  // Pin conditioning; nothing here reads a first sync stage
  svs_line_cond u_cond (
    .clk            (clk),
    .rst_b          (rst_b),
    .link_clock_pin (vid_link_clock),
    .link_data_pin  (vid_link_data_in),
    .power_ok_pin   (processor_power_ok),
    .line           (line)
  );

  // Byte in shift_r holds address in [7:1], write bit in [0]
  // Reserved bit 3 is deliberately left out of the check
  assign addr_valid = (shift_r[svs_pkg::ADDR_PAT_MSB+1:svs_pkg::ADDR_PAT_LSB+1]
                       == svs_pkg::ADDR_PATTERN) && !shift_r[0];
  // Every one of the 256 data values is a defined code
  assign data_valid = 1'b1;

  // Stop after both acknowledges is the only way to commit
  assign commit = line.stop && (state_r == svs_pkg::SVS_WAIT_STOP)
                  && addr_ok_r && data_ok_r;

  // Receiver state machine
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= svs_pkg::SVS_IDLE;
    end else if (!line.power_ok) begin
      // Link ignored until the processor says power is good
      state_r <= svs_pkg::SVS_IDLE;
    end else if (line.start) begin
      // Start, or repeated start, always opens a fresh command
      state_r <= svs_pkg::SVS_ADDR;
    end else if (line.stop) begin
      // Any stop ends the frame; commit handled elsewhere
      state_r <= svs_pkg::SVS_IDLE;
    end else begin
      unique case (state_r)
        svs_pkg::SVS_IDLE: begin
          state_r <= svs_pkg::SVS_IDLE;
        end
        svs_pkg::SVS_ADDR: begin
          // Ninth-clock slot opens on the fall after bit eight
          if (line.clk_fall && bit_cnt_r == svs_pkg::BYTE_BITS) begin
            state_r <= svs_pkg::SVS_ADDR_ACK;
          end
        end
        svs_pkg::SVS_ADDR_ACK: begin
          if (line.clk_fall) begin
            state_r <= addr_ok_r ? svs_pkg::SVS_DATA : svs_pkg::SVS_IDLE;
          end
        end
        svs_pkg::SVS_DATA: begin
          if (line.clk_fall && bit_cnt_r == svs_pkg::BYTE_BITS) begin
            state_r <= svs_pkg::SVS_DATA_ACK;
          end
        end
        svs_pkg::SVS_DATA_ACK: begin
          if (line.clk_fall) begin
            state_r <= data_ok_r ? svs_pkg::SVS_WAIT_STOP : svs_pkg::SVS_IDLE;
          end
        end
        svs_pkg::SVS_WAIT_STOP: begin
          // Extra clocks before the stop are simply ignored
          state_r <= svs_pkg::SVS_WAIT_STOP;
        end
        default: begin
          state_r <= svs_pkg::SVS_IDLE;
        end
      endcase
    end
  end

  // Bit shifter and counter, sampling data on clock rise
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_r   <= 8'h00;
      bit_cnt_r <= 4'h0;
    end else if (line.start || state_r == svs_pkg::SVS_ADDR_ACK
                 || state_r == svs_pkg::SVS_DATA_ACK) begin
      bit_cnt_r <= 4'h0;
    end else if (line.clk_rise && bit_cnt_r != svs_pkg::BYTE_BITS
                 && (state_r == svs_pkg::SVS_ADDR || state_r == svs_pkg::SVS_DATA)) begin
      shift_r   <= {shift_r[6:0], line.data};
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end
  end

  // Latch each byte and its verdict as its slot opens
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_byte_r <= 8'h00;
      data_byte_r <= 8'h00;
      addr_ok_r   <= 1'b0;
      data_ok_r   <= 1'b0;
    end else if (line.start || state_r == svs_pkg::SVS_IDLE) begin
      // Fresh frame forgets any half-received command
      addr_ok_r <= 1'b0;
      data_ok_r <= 1'b0;
    end else if (line.clk_fall && bit_cnt_r == svs_pkg::BYTE_BITS) begin
      if (state_r == svs_pkg::SVS_ADDR) begin
        addr_byte_r <= shift_r;
        addr_ok_r   <= addr_valid;
      end else if (state_r == svs_pkg::SVS_DATA) begin
        data_byte_r <= shift_r;
        data_ok_r   <= data_valid;
      end
    end
  end

  // Acknowledge driver: pull data low through the whole slot
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vid_link_data_oe_n <= 1'b1;
      vid_link_data_out  <= 1'b0;
    end else if (!line.power_ok || line.start || line.stop) begin
      vid_link_data_oe_n <= 1'b1;
    end else if (line.clk_fall && bit_cnt_r == svs_pkg::BYTE_BITS) begin
      if (state_r == svs_pkg::SVS_ADDR) begin
        vid_link_data_oe_n <= !addr_valid;
      end else if (state_r == svs_pkg::SVS_DATA) begin
        vid_link_data_oe_n <= !data_valid;
      end
    end else if (line.clk_fall) begin
      // Release on the fall that ends the slot
      vid_link_data_oe_n <= 1'b1;
    end
  end

  // Power-ok history spots its drop; strap is caught one cycle after release
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pok_prev_r   <= 1'b0;
      strap_done_r <= 1'b0;
    end else begin
      pok_prev_r   <= line.power_ok;
      strap_done_r <= 1'b1;
    end
  end

  // Plane targets, hint and off flags
  // Off flags move in the same cycle as codes, so they never disagree
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      core_plane_a_code   <= svs_pkg::CODE_RESET;
      core_plane_b_code   <= svs_pkg::CODE_RESET;
      bridge_plane_code   <= svs_pkg::CODE_RESET;
      core_plane_a_off    <= 1'b0;
      core_plane_b_off    <= 1'b0;
      bridge_plane_off    <= 1'b0;
      power_saving_hint_n <= svs_pkg::HINT_RESET;
    end else if (!strap_done_r || (pok_prev_r && !line.power_ok)) begin
      // Start-up level; also fallen back to on power-ok loss
      core_plane_a_code   <= startup_code;
      core_plane_b_code   <= startup_code;
      bridge_plane_code   <= startup_code;
      core_plane_a_off    <= startup_code >= svs_pkg::CODE_OFF_MIN;
      core_plane_b_off    <= startup_code >= svs_pkg::CODE_OFF_MIN;
      bridge_plane_off    <= startup_code >= svs_pkg::CODE_OFF_MIN;
      power_saving_hint_n <= svs_pkg::HINT_RESET;
    end else if (commit) begin
      if (addr_byte_r[svs_pkg::SEL_CORE_B_BIT+1]) begin
        core_plane_b_code <= data_byte_r[svs_pkg::CODE_MSB:0];
        core_plane_b_off  <= data_byte_r[svs_pkg::CODE_MSB:0]
                             >= svs_pkg::CODE_OFF_MIN;
      end
      if (addr_byte_r[svs_pkg::SEL_CORE_A_BIT+1]) begin
        core_plane_a_code <= data_byte_r[svs_pkg::CODE_MSB:0];
        core_plane_a_off  <= data_byte_r[svs_pkg::CODE_MSB:0]
                             >= svs_pkg::CODE_OFF_MIN;
      end
      if (addr_byte_r[svs_pkg::SEL_BRIDGE_BIT+1]) begin
        bridge_plane_code <= data_byte_r[svs_pkg::CODE_MSB:0];
        bridge_plane_off  <= data_byte_r[svs_pkg::CODE_MSB:0]
                             >= svs_pkg::CODE_OFF_MIN;
      end
      power_saving_hint_n <= data_byte_r[svs_pkg::HINT_BIT];
    end
  end

  // One-cycle notice to the stepping logic that targets changed
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      targets_update <= 1'b0;
    end else begin
      targets_update <= commit && strap_done_r && !(pok_prev_r && !line.power_ok);
    end
  end

  // Checks
  property p_addr_ack_valid;
    @(posedge clk) disable iff (!rst_b)
    (state_r == svs_pkg::SVS_ADDR_ACK && !vid_link_data_oe_n) |-> addr_ok_r
      && addr_byte_r[7:5] == svs_pkg::ADDR_PATTERN && !addr_byte_r[0];
  endproperty
  a_addr_ack_valid: assert property (p_addr_ack_valid)
    else $error("address acknowledged while invalid");
  property p_nack_invalid;
    @(posedge clk) disable iff (!rst_b)
    (line.power_ok && !line.start && !line.stop && line.clk_fall
     && state_r == svs_pkg::SVS_ADDR && bit_cnt_r == svs_pkg::BYTE_BITS && !addr_valid)
      |=> vid_link_data_oe_n && !addr_ok_r;
  endproperty
  a_nack_invalid: assert property (p_nack_invalid)
    else $error("invalid address not refused");
  property p_update_after_stop;
    @(posedge clk) disable iff (!rst_b)
    targets_update |-> $past(line.stop) && $past(state_r == svs_pkg::SVS_WAIT_STOP);
  endproperty
  a_update_after_stop: assert property (p_update_after_stop)
    else $error("targets updated without a stop");
  property p_plane_b_load;
    @(posedge clk) disable iff (!rst_b)
    (commit && strap_done_r && !(pok_prev_r && !line.power_ok)) |=>
      (core_plane_b_code == ($past(addr_byte_r[3]) ? $past(data_byte_r[6:0])
                                                   : $past(core_plane_b_code)));
  endproperty
  a_plane_b_load: assert property (p_plane_b_load)
    else $error("second core plane target wrong");
  property p_plane_a_bridge_load;
    @(posedge clk) disable iff (!rst_b)
    targets_update && $past(addr_byte_r[2]) && $past(addr_byte_r[1]) |->
      core_plane_a_code == bridge_plane_code;
  endproperty
  a_plane_a_bridge_load: assert property (p_plane_a_bridge_load)
    else $error("multi-plane command split");
  property p_hint_load;
    @(posedge clk) disable iff (!rst_b)
    targets_update |-> power_saving_hint_n == $past(data_byte_r[7]);
  endproperty
  a_hint_load: assert property (p_hint_load)
    else $error("hint not taken from data bit 7");
  property p_targets_hold;
    @(posedge clk) disable iff (!rst_b)
    (strap_done_r && !targets_update && $past(strap_done_r) && line.power_ok
     && $past(line.power_ok)) |-> $stable(core_plane_a_code) && $stable(core_plane_b_code)
      && $stable(bridge_plane_code) && $stable(power_saving_hint_n);
  endproperty
  a_targets_hold: assert property (p_targets_hold)
    else $error("targets changed without a command");
  property p_off_flag;
    @(posedge clk) disable iff (!rst_b)
    strap_done_r |=> core_plane_a_off == (core_plane_a_code >= svs_pkg::CODE_OFF_MIN)
      && bridge_plane_off == (bridge_plane_code >= svs_pkg::CODE_OFF_MIN);
  endproperty
  a_off_flag: assert property (p_off_flag)
    else $error("off flag disagrees with code");
  property p_quiet_without_power;
    @(posedge clk) disable iff (!rst_b)
    !line.power_ok |=> state_r == svs_pkg::SVS_IDLE && vid_link_data_oe_n;
  endproperty
  a_quiet_without_power: assert property (p_quiet_without_power)
    else $error("link active without power-ok");
  property p_startup;
    @(posedge clk) disable iff (!rst_b)
    $rose(strap_done_r) |-> core_plane_a_code == $past(startup_code, 1)
      && !targets_update;
  endproperty
  a_startup: assert property (p_startup)
    else $error("start-up code not loaded");
  property p_cov_commit;
    @(posedge clk) disable iff (!rst_b) targets_update;
  endproperty
  c_cov_commit: cover property (p_cov_commit);
  property p_cov_nack;
    @(posedge clk) disable iff (!rst_b)
    state_r == svs_pkg::SVS_ADDR_ACK && !addr_ok_r;
  endproperty
  c_cov_nack: cover property (p_cov_nack);
  property p_cov_off;
    @(posedge clk) disable iff (!rst_b) targets_update && core_plane_a_off;
  endproperty
  c_cov_off: cover property (p_cov_off);

endmodule // svs_slave
`default_nettype wire
